/* File: hw/adc_ctrl_defines.vh */
// Register offsets, field positions and reset values of the converter control block
//
// Contract
// - The five-bit scan trigger select field in bits 20-16 picks none, software edge, software level, external interrupt 0, timer 1/3/5 match, output compare 1/3/5 or comparator 1/2.
// - Bit 15 at one enables the converter module, at zero keeps it disabled.
// - Bit 13 at one halts converter operation during system idle, at zero lets it continue.
// - Bit 12 switches the analog input charge pump on or off and is one after reset.
// - Bit 11 enables capacitive voltage division when one.
// - Bit 10 routes the fast synchronous system clock to the converter control clock when one.
// - Bit 9 routes the fast synchronous peripheral clock to the converter control clock when one.
// - Bits 14, 8 and 7 of the control word are unimplemented and read as zero.
// - The three-bit vector shift field in bits 6-4 gives a left shift of zero to seven places.
// - The shifted operand is the lowest-numbered active input among the two ready status registers.
// - Reading the vector base register returns the written base plus that input number shifted left.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define CONTROL_ONE_ADDR 12'h000
`define VECTOR_BASE_ADDR 12'h004
`define READY_FIRST_ADDR 12'h008
`define READY_SECOND_ADDR 12'h00c
`define SOFT_TRIGGER_ADDR 12'h010
`define STATUS_ADDR 12'h014

// ************************************************************
// Control word fields
// ************************************************************
`define TRIG_SEL_MSB 20
`define TRIG_SEL_LSB 16
`define ENABLE_BIT 15
`define IDLE_HALT_BIT 13
`define PUMP_BIT 12
`define CAP_DIV_BIT 11
`define FAST_SYSCLK_BIT 10
`define FAST_PERIPH_BIT 9
`define SHIFT_MSB 6
`define SHIFT_LSB 4
`define CONTROL_ONE_MASK 32'h001fbe70
`define CONTROL_ONE_RESET 32'h00001000
`define VECTOR_BASE_RESET 32'h00000000

// ************************************************************
// Trigger select codes
// ************************************************************
`define TRIG_NONE 5'h00
`define TRIG_SOFT_EDGE 5'h01
`define TRIG_SOFT_LEVEL 5'h02
`define TRIG_EXT_INT0 5'h04
`define TRIG_TIMER1 5'h05
`define TRIG_TIMER3 5'h06
`define TRIG_TIMER5 5'h07
`define TRIG_OUT_COMPARE1 5'h08
`define TRIG_OUT_COMPARE3 5'h09
`define TRIG_OUT_COMPARE5 5'h0a
`define TRIG_CMP1 5'h0b
`define TRIG_CMP2 5'h0c

// ************************************************************
// Software trigger register fields
// ************************************************************
`define SOFT_EDGE_BIT 0
`define SOFT_LEVEL_BIT 1

`endif

/* File: hw/adc_ctrl.v */
// Converter control word, scan trigger selection and vector address forming behind an APB slave
`include "adc_ctrl_defines.vh"

module adc_ctrl
(
  core_clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  idle_mode,
  external_interrupt_zero,
  timer_first_match,
  timer_third_match,
  timer_fifth_match,
  output_compare_first,
  output_compare_third,
  output_compare_fifth,
  comparator_output_first,
  comparator_output_second,
  input_ready_flag,
  converter_enable,
  converter_run,
  scan_trigger,
  input_charge_pump_enable,
  cap_voltage_divide_enable,
  fast_sysclk_path_enable,
  fast_periph_clock_path_enable
);
  input wire core_clk;
  input wire rst;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output wire [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire idle_mode;
  input wire external_interrupt_zero;
  input wire timer_first_match;
  input wire timer_third_match;
  input wire timer_fifth_match;
  input wire output_compare_first;
  input wire output_compare_third;
  input wire output_compare_fifth;
  input wire comparator_output_first;
  input wire comparator_output_second;
  input wire [63:0] input_ready_flag;
  output wire converter_enable;
  output wire converter_run;
  output wire scan_trigger;
  output wire input_charge_pump_enable;
  output wire cap_voltage_divide_enable;
  output wire fast_sysclk_path_enable;
  output wire fast_periph_clock_path_enable;

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [31:0] control_one_reg;
  reg [31:0] vector_base_reg;
  reg soft_level_reg;
  reg soft_edge_reg;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg pready_reg;
  reg pslverr_reg;
  reg pslverr_next;
  reg run_reg;
  reg scan_trigger_reg;
  reg scan_trigger_next;
  reg [9:0] sync_a_reg;
  reg [9:0] sync_b_reg;
  reg [8:0] src_prev_reg;
  reg [63:0] ready_a_reg;
  reg [63:0] ready_b_reg;
  reg [5:0] lowest_id;
  reg any_ready;
  reg [31:0] vector_value;
  reg src_sel;
  reg src_sel_prev;
  reg sel_is_level;
  reg sel_valid;
  integer i;

  wire [9:0] async_in;
  wire idle_sync;
  wire [8:0] src_sync;
  wire [4:0] trig_sel;
  wire [2:0] vec_shift;
  wire setup_phase;
  wire access_done;
  wire wr_control;
  wire wr_base;
  wire wr_soft;
  wire [4:0] src_offset;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  assign async_in = {idle_mode, comparator_output_second, comparator_output_first,
    output_compare_fifth, output_compare_third, output_compare_first,
    timer_fifth_match, timer_third_match, timer_first_match, external_interrupt_zero};

  // Every pin-side input sees two flops before any logic reads it
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1)
    begin : gen_sync
      always @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          sync_a_reg[g] <= 1'b0;
          sync_b_reg[g] <= 1'b0;
        end
        else
        begin
          sync_a_reg[g] <= async_in[g];
          sync_b_reg[g] <= sync_a_reg[g];
        end
      end
    end
  endgenerate

  assign idle_sync = sync_b_reg[9];
  assign src_sync = sync_b_reg[8:0];

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ready_a_reg <= 64'h0000000000000000;
      ready_b_reg <= 64'h0000000000000000;
    end
    else
    begin
      ready_a_reg <= input_ready_flag;
      ready_b_reg <= ready_a_reg;
    end
  end

  // ************************************************************
  // Field views of the control word
  // ************************************************************
  assign trig_sel = control_one_reg[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
  assign vec_shift = control_one_reg[`SHIFT_MSB:`SHIFT_LSB];
  assign src_offset = trig_sel - `TRIG_EXT_INT0;

  assign converter_enable = control_one_reg[`ENABLE_BIT];
  assign input_charge_pump_enable = control_one_reg[`PUMP_BIT];
  assign cap_voltage_divide_enable = control_one_reg[`CAP_DIV_BIT];
  assign fast_sysclk_path_enable = control_one_reg[`FAST_SYSCLK_BIT];
  assign fast_periph_clock_path_enable = control_one_reg[`FAST_PERIPH_BIT];
  assign converter_run = run_reg;
  assign scan_trigger = scan_trigger_reg;

  // ************************************************************
  // APB decode
  // ************************************************************
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_control = access_done & pwrite & (paddr == `CONTROL_ONE_ADDR);
  assign wr_base = access_done & pwrite & (paddr == `VECTOR_BASE_ADDR);
  assign wr_soft = access_done & pwrite & (paddr == `SOFT_TRIGGER_ADDR);

  // ************************************************************
  // Lowest active ready input and vector address
  // ************************************************************
  // Scan from the top down so the lowest set index is the last one to win
  always @*
  begin
    lowest_id = 6'h00;
    any_ready = 1'b0;
    for (i = 63; i >= 0; i = i - 1)
    begin
      if (ready_b_reg[i])
      begin
        lowest_id = i[5:0];
        any_ready = 1'b1;
      end
    end
  end

  // With no input ready the read gives the plain base value
  always @*
  begin
    vector_value = vector_base_reg;
    if (any_ready)
    begin
      vector_value = vector_base_reg + ({26'h0000000, lowest_id} << vec_shift);
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  always @*
  begin
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    case (paddr)
      `CONTROL_ONE_ADDR: prdata_next = control_one_reg & `CONTROL_ONE_MASK;
      `VECTOR_BASE_ADDR: prdata_next = vector_value;
      `READY_FIRST_ADDR: prdata_next = ready_b_reg[31:0];
      `READY_SECOND_ADDR: prdata_next = ready_b_reg[63:32];
      `SOFT_TRIGGER_ADDR: prdata_next = {30'h00000000, soft_level_reg, 1'b0};
      `STATUS_ADDR: prdata_next = {30'h00000000, idle_sync, run_reg};
      // Unmapped words are refused with an error and zero data
      default: pslverr_next = 1'b1;
    endcase
  end

  // Read data is latched in setup, so every access costs exactly one wait-free access cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup_phase;
      if (setup_phase)
      begin
        prdata_reg <= pwrite ? 32'h00000000 : prdata_next;
        pslverr_reg <= pslverr_next;
      end
      else if (access_done)
      begin
        prdata_reg <= 32'h00000000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ************************************************************
  // Writable registers
  // ************************************************************
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      control_one_reg <= `CONTROL_ONE_RESET;
      vector_base_reg <= `VECTOR_BASE_RESET;
      soft_level_reg <= 1'b0;
      soft_edge_reg <= 1'b0;
    end
    else
    begin
      if (wr_control)
      begin
        // Unimplemented bits never store, so they cannot read back
        control_one_reg <= pwdata & `CONTROL_ONE_MASK;
      end
      if (wr_base)
      begin
        vector_base_reg <= pwdata;
      end
      if (wr_soft)
      begin
        soft_level_reg <= pwdata[`SOFT_LEVEL_BIT];
      end
      soft_edge_reg <= wr_soft & pwdata[`SOFT_EDGE_BIT];
    end
  end

  // ************************************************************
  // Run state
  // ************************************************************
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_reg <= 1'b0;
    end
    else
    begin
      run_reg <= control_one_reg[`ENABLE_BIT] & ~(control_one_reg[`IDLE_HALT_BIT] & idle_sync);
    end
  end

  // ************************************************************
  // Trigger source selection
  // ************************************************************
  always @*
  begin
    src_sel = 1'b0;
    src_sel_prev = 1'b0;
    sel_is_level = 1'b0;
    sel_valid = 1'b1;
    case (trig_sel)
      `TRIG_NONE: sel_valid = 1'b0;
      `TRIG_SOFT_EDGE: src_sel = soft_edge_reg;
      `TRIG_SOFT_LEVEL:
      begin
        src_sel = soft_level_reg;
        sel_is_level = 1'b1;
      end
      // Hardware sources sit on the synchroniser in code order, from bit 0 upward
      `TRIG_EXT_INT0, `TRIG_TIMER1, `TRIG_TIMER3, `TRIG_TIMER5, `TRIG_OUT_COMPARE1, `TRIG_OUT_COMPARE3,
      `TRIG_OUT_COMPARE5, `TRIG_CMP1, `TRIG_CMP2:
      begin
        src_sel = src_sync[src_offset[3:0]];
        src_sel_prev = src_prev_reg[src_offset[3:0]];
      end
      default: sel_valid = 1'b0;
    endcase
  end

  // Hardware sources fire on a rising edge; the soft edge bit is already a pulse
  always @*
  begin
    scan_trigger_next = 1'b0;
    if (run_reg & sel_valid)
    begin
      if (sel_is_level | (trig_sel == `TRIG_SOFT_EDGE))
      begin
        scan_trigger_next = src_sel;
      end
      else
      begin
        scan_trigger_next = src_sel & ~src_sel_prev;
      end
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      src_prev_reg <= 9'h000;
      scan_trigger_reg <= 1'b0;
    end
    else
    begin
      src_prev_reg <= src_sync;
      scan_trigger_reg <= scan_trigger_next;
    end
  end

endmodule

/* File: verif/adc_ctrl_asserts.sv */
// Concurrent checks on the converter control block ports
module adc_ctrl_asserts (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire converter_enable,
  input wire converter_run,
  input wire input_charge_pump_enable,
  input wire cap_voltage_divide_enable,
  input wire fast_sysclk_path_enable,
  input wire fast_periph_clock_path_enable
);
  // ************
  // Bus and control word checks
  // ************
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Completing write to the control word
  sequence ctl_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  a_bus_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_idle_bus_zero: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("bus outputs not quiet");
  a_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_enable_write: assert property (ctl_wr |=> converter_enable == $past(pwdata[15]))
    else $error("enable not taken from write");
  a_pump_write: assert property (ctl_wr |=> input_charge_pump_enable == $past(pwdata[12]))
    else $error("pump enable not taken from write");
  a_cap_write: assert property (ctl_wr |=> cap_voltage_divide_enable == $past(pwdata[11]))
    else $error("divide enable not taken from write");
  a_sysclk_write: assert property (ctl_wr |=> fast_sysclk_path_enable == $past(pwdata[10]))
    else $error("system clock path not taken from write");
  a_periph_write: assert property (ctl_wr |=> fast_periph_clock_path_enable == $past(pwdata[9]))
    else $error("peripheral clock path not taken from write");
  a_run_gate: assert property (!converter_enable |=> !converter_run)
    else $error("running while disabled");
endmodule

bind adc_ctrl adc_ctrl_asserts chk_i (.*);

/* File: verif/tb.sv */
// Self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, idle_mode = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [8:0] src = 9'h000;
  logic [63:0] input_ready_flag = 64'h0000000000000000;
  wire [31:0] prdata;
  wire pready, pslverr, converter_enable, converter_run, scan_trigger, input_charge_pump_enable;
  wire cap_voltage_divide_enable, fast_sysclk_path_enable, fast_periph_clock_path_enable;
  int errors = 0, n_compared = 0, cyc = 0, hits = 0;
  // ************
  // Device and clock
  // ************
  adc_ctrl uut (.*, .external_interrupt_zero(src[0]), .timer_first_match(src[1]), .timer_third_match(src[2]),
    .timer_fifth_match(src[3]), .output_compare_first(src[4]), .output_compare_third(src[5]),
    .output_compare_fifth(src[6]), .comparator_output_first(src[7]), .comparator_output_second(src[8]));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (scan_trigger === 1'b1)
      hits++;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end
  // ************
  // Shared tasks
  // ************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Waits for ready without assuming a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_regs();
    apb(0, 12'h000, 0);
    chk(rd, 32'h00001000);
    apb(1, 12'h000, 32'hffff7fff);
    apb(0, 12'h000, 0);
    chk(rd, 32'h001f3e70);
    chk({input_charge_pump_enable, cap_voltage_divide_enable, fast_sysclk_path_enable,
      fast_periph_clock_path_enable, converter_enable}, 5'h1e);
    apb(1, 12'h000, 0);
    @(posedge core_clk);
    chk({input_charge_pump_enable, cap_voltage_divide_enable, fast_sysclk_path_enable,
      fast_periph_clock_path_enable}, 4'h0);
    apb(0, 12'h020, 0);
    chk(rd, 32'h00000000);
    chk({31'h00000000, er}, 32'h00000001);
  endtask
  task automatic t_idle();
    idle_mode <= 1;
    apb(1, 12'h000, 32'h00002000);
    apb(1, 12'h000, 32'h0000a000);
    repeat (5) @(posedge core_clk);
    chk({converter_enable, converter_run}, 2'b10);
    idle_mode <= 0;
    repeat (5) @(posedge core_clk);
    chk({converter_enable, converter_run}, 2'b11);
    idle_mode <= 1;
    apb(1, 12'h000, 32'h00008000);
    repeat (5) @(posedge core_clk);
    chk({converter_enable, converter_run}, 2'b11);
    idle_mode <= 0;
    apb(1, 12'h000, 0);
    repeat (2) @(posedge core_clk);
    chk({converter_enable, converter_run}, 2'b00);
  endtask
  // Only the selected source may fire; the soft edge bit pulses every pass, and all hardware sources pulse unless one is selected
  task automatic t_trig();
    for (int k = 0; k < 32; k++)
    begin
      apb(1, 12'h000, k << 16);
      apb(1, 12'h000, (k << 16) | 32'h00008000);
      repeat (3) @(posedge core_clk);
      hits = 0;
      src <= (k >= 4 && k <= 12) ? 9'h001 << (k - 4) : 9'h1ff;
      apb(1, 12'h010, 32'h00000001);
      src <= 9'h000;
      repeat (8) @(posedge core_clk);
      chk(hits, k == 1 || (k >= 4 && k <= 12));
    end
    apb(1, 12'h000, 32'h00020000);
    apb(1, 12'h000, 32'h00028000);
    apb(1, 12'h010, 32'h00000002);
    repeat (6) @(posedge core_clk);
    chk(scan_trigger, 1);
    apb(1, 12'h010, 0);
    repeat (2) @(posedge core_clk);
    chk(scan_trigger, 0);
  endtask
  task automatic t_vec();
    apb(1, 12'h004, 32'h00001000);
    input_ready_flag <= 64'h0000012000000000;
    for (int s = 0; s < 8; s++)
    begin
      apb(1, 12'h000, s << 4);
      apb(0, 12'h004, 0);
      chk(rd, 32'h00001000 + (37 << s));
    end
    input_ready_flag <= 64'h0004000000000008;
    repeat (4) @(posedge core_clk);
    apb(0, 12'h004, 0);
    chk(rd, 32'h00001000 + (3 << 7));
    input_ready_flag <= 64'h0000000000000000;
    repeat (4) @(posedge core_clk);
    apb(0, 12'h004, 0);
    chk(rd, 32'h00001000);
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    t_regs();
    t_idle();
    t_trig();
    t_vec();
    close_out();
  end
endmodule
